// file: rtl/bds_pkg.sv
`default_nettype none
package bds_pkg;
  localparam int unsigned CLK_HZ           = 200_000_000;
  // Short detection delays in nanoseconds, indexed by the delay code
  localparam int unsigned DLY3200_NS       = 3200;
  localparam int unsigned DLY1600_NS       = 1600;
  localparam int unsigned DLY1200_NS       = 1200;
  localparam int unsigned DLY800_NS        = 800;
  localparam int unsigned DLY3200_CYC      = (DLY3200_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DLY1600_CYC      = (DLY1600_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DLY1200_CYC      = (DLY1200_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DLY800_CYC       = (DLY800_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W            = 10;
  localparam int unsigned RETRIES          = 3;
  localparam logic [1:0]  RETRY_MAX        = 2'(RETRIES);
  localparam logic [CNT_W-1:0] CNT_RESET   = '0;
  // Disable synchroniser comes out of reset reading disabled
  localparam logic [1:0]  DIS_SYNC_RST     = 2'h3;

  typedef enum logic [1:0] {BDS_DRV_MIN, BDS_DRV_MIN_TC, BDS_DRV_MED, BDS_DRV_MAX} bds_drive_t;

  typedef enum {BDS_OFF, BDS_WAIT_GATE, BDS_ON} bds_phase_t;

  typedef struct packed {
    logic [1:0] lowside_slope_sel;
    logic [1:0] highside_slope_sel;
    logic [3:0] chopper_off_time;
    logic       hs_short_sensitivity;
    logic [1:0] short_detect_delay;
    logic       short_protect_disable;
    logic       lowside_short_enable;
  } bds_cfg_t;

  typedef struct packed {
    logic coil_a_short_flag;
    logic coil_b_short_flag;
    logic coil_a_lowside_fault;
    logic coil_b_lowside_fault;
    logic coil_a_highside_fault;
    logic coil_b_highside_fault;
  } bds_status_t;
endpackage : bds_pkg
`default_nettype wire

// file: rtl/bds_bridge.sv
`default_nettype none
// Behaviour
// (R1) Low-side drive: codes 0 and 1 minimum, 2 medium, 3 maximum.
// (R2) High-side drive: minimum, minimum+TC, medium+TC, maximum by code.
// (R3) Host should program high-side slope equal to low-side slope.
// (R4) A switch turns on only after the opposite gate senses discharged.
// (R5) Disable pin high turns every bridge switch off; host ties low otherwise.
// (R6) Zero off-time disables bridges like the disable pin.
// (R7) A short is retried three times before the bridge is latched off.
// (R8) Low-side detector is inactive unless its enable bit is set.
// (R9) Sensitivity bit selects high-side threshold: 0 low, 1 high.
// (R10) Delay code selects 3.2, 1.6, 1.2 or 0.8 us detection delay.
// (R11) Protection-disable bit set turns high-side short protection off.
// (R12) Per-coil short flags set only for shorts persisting over several cycles.
// (R13) All short flags clear while the bridges are disabled.
// (R14) Separate low-side and high-side fault flags per coil.
// (R15) A confirmed short switches off only the affected coil's bridge.
// (R16) A latched-off bridge stays off until disable then re-enable.
// (R17) All timing derives from the system clock.
// (R18) Comparators are sampled only after the delay count after each switch.
module bds_bridge
  import bds_pkg::*;
(
  input  wire logic  clk_i,                  // System clock
  input  wire logic  reset_i,                // Async reset, active high
  input  wire logic  bridge_disable_n_pin_i, // Disable pin, high disables
  input  wire bds_cfg_t cfg_i,               // Configuration fields
  input  wire logic [1:0] phase_hi_i,        // Unused input; wanted high-side state comes from hs_want_i
  input  wire logic [3:0] hs_want_i,         // Wanted high-side state, A1 A2 B1 B2
  input  wire logic [3:0] hs_gate_off_i,     // High-side gate sensed discharged
  input  wire logic [3:0] ls_gate_off_i,     // Low-side gate sensed discharged
  input  wire logic [1:0] hs_cmp_low_i,      // High-side comparator, low threshold, per coil
  input  wire logic [1:0] hs_cmp_high_i,     // High-side comparator, high threshold, per coil
  input  wire logic [1:0] ls_cmp_i,          // Low-side comparator per coil
  output logic [3:0] hs_on_o,                // High-side gate command
  output logic [3:0] ls_on_o,                // Low-side gate command
  output logic [1:0] ls_drive_o,             // Low-side gate current
  output bds_drive_t hs_drive_o,             // High-side gate current
  output logic       hs_threshold_high_o,    // High-side detector sensitivity
  output bds_status_t status_o               // Short status flags
);
  typedef struct packed {
    logic [1:0] dis_sync;
    logic [3:0] gate_hs_s1, gate_hs_s2;
    logic [3:0] gate_ls_s1, gate_ls_s2;
    logic [1:0] hl_s1, hl_s2, hh_s1, hh_s2, lc_s1, lc_s2;
    logic [3:0] want_s1, want_s2, want_prev;
    logic [3:0] hs_on, ls_on;
    logic [CNT_W-1:0] cnt_a, cnt_b;
    logic [1:0] tries_a, tries_b;
    logic [1:0] off_latched;
    bds_status_t st;
  } bds_state_t;

  bds_state_t s_q, s_d;
  logic             disabled;
  logic [CNT_W-1:0] dly;
  logic [1:0]       hs_fault, ls_fault;
  logic [1:0]       sw_event;
  logic [1:0]       ls_code;

  always_comb begin
    unique case (cfg_i.short_detect_delay) // [R10] [R17]
      2'h0:    dly = CNT_W'(DLY3200_CYC);
      2'h1:    dly = CNT_W'(DLY1600_CYC);
      2'h2:    dly = CNT_W'(DLY1200_CYC);
      default: dly = CNT_W'(DLY800_CYC);
    endcase
  end

  assign ls_code = (cfg_i.lowside_slope_sel == 2'h1) ? 2'h0 : cfg_i.lowside_slope_sel; // [R1]

  always_comb begin
    s_d = s_q;
    disabled = s_q.dis_sync[1] | (cfg_i.chopper_off_time == 4'h0); // [R5] [R6]
    hs_fault[0] = ~cfg_i.short_protect_disable &
                  (cfg_i.hs_short_sensitivity ? s_q.hh_s2[0] : s_q.hl_s2[0]); // [R9] [R11]
    hs_fault[1] = ~cfg_i.short_protect_disable &
                  (cfg_i.hs_short_sensitivity ? s_q.hh_s2[1] : s_q.hl_s2[1]); // [R9] [R11]
    ls_fault = cfg_i.lowside_short_enable ? s_q.lc_s2 : 2'h0; // [R8]
    sw_event[0] = |(s_q.want_s2[1:0] ^ s_q.want_prev[1:0]);
    sw_event[1] = |(s_q.want_s2[3:2] ^ s_q.want_prev[3:2]);

    s_d.dis_sync   = {s_q.dis_sync[0], bridge_disable_n_pin_i};
    s_d.gate_hs_s1 = hs_gate_off_i;
    s_d.gate_hs_s2 = s_q.gate_hs_s1;
    s_d.gate_ls_s1 = ls_gate_off_i;
    s_d.gate_ls_s2 = s_q.gate_ls_s1;
    s_d.hl_s1 = hs_cmp_low_i;
    s_d.hl_s2 = s_q.hl_s1;
    s_d.hh_s1 = hs_cmp_high_i;
    s_d.hh_s2 = s_q.hh_s1;
    s_d.lc_s1 = ls_cmp_i;
    s_d.lc_s2 = s_q.lc_s1;
    s_d.want_s1 = hs_want_i;
    s_d.want_s2 = s_q.want_s1;
    s_d.want_prev = s_q.want_s2;

    // Blanking counters restart on every switching event of the coil
    s_d.cnt_a = sw_event[0] ? dly : ((s_q.cnt_a != CNT_RESET) ? s_q.cnt_a - CNT_W'(1) : s_q.cnt_a); // [R18]
    s_d.cnt_b = sw_event[1] ? dly : ((s_q.cnt_b != CNT_RESET) ? s_q.cnt_b - CNT_W'(1) : s_q.cnt_b); // [R18]

    if (s_q.cnt_a == CNT_RESET && !sw_event[0] && (hs_fault[0] | ls_fault[0]) && !s_q.off_latched[0]) begin
      if (s_q.tries_a == RETRY_MAX) begin // [R7]
        s_d.off_latched[0] = 1'b1; // [R15]
        s_d.st.coil_a_short_flag = 1'b1; // [R12]
        s_d.st.coil_a_highside_fault = s_q.st.coil_a_highside_fault | hs_fault[0]; // [R14]
        s_d.st.coil_a_lowside_fault = s_q.st.coil_a_lowside_fault | ls_fault[0]; // [R14]
      end else begin
        s_d.tries_a = s_q.tries_a + 2'h1; // [R7]
        s_d.cnt_a = dly;
      end
    end
    if (s_q.cnt_b == CNT_RESET && !sw_event[1] && (hs_fault[1] | ls_fault[1]) && !s_q.off_latched[1]) begin
      if (s_q.tries_b == RETRY_MAX) begin // [R7]
        s_d.off_latched[1] = 1'b1; // [R15]
        s_d.st.coil_b_short_flag = 1'b1; // [R12]
        s_d.st.coil_b_highside_fault = s_q.st.coil_b_highside_fault | hs_fault[1]; // [R14]
        s_d.st.coil_b_lowside_fault = s_q.st.coil_b_lowside_fault | ls_fault[1]; // [R14]
      end else begin
        s_d.tries_b = s_q.tries_b + 2'h1; // [R7]
        s_d.cnt_b = dly;
      end
    end

    for (int i = 0; i < 4; i++) begin
      if (disabled || s_q.off_latched[i/2]) begin
        s_d.hs_on[i] = 1'b0; // [R5] [R15]
        s_d.ls_on[i] = 1'b0;
      end else if (s_q.want_s2[i]) begin
        s_d.ls_on[i] = 1'b0;
        s_d.hs_on[i] = s_q.hs_on[i] | (~s_q.ls_on[i] & s_q.gate_ls_s2[i]); // [R4]
      end else begin
        s_d.hs_on[i] = 1'b0;
        s_d.ls_on[i] = s_q.ls_on[i] | (~s_q.hs_on[i] & s_q.gate_hs_s2[i]); // [R4]
      end
    end

    if (disabled) begin
      s_d.st = '0; // [R13]
      s_d.off_latched = 2'h0; // [R16]
      s_d.tries_a = 2'h0;
      s_d.tries_b = 2'h0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.dis_sync <= DIS_SYNC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign hs_on_o = s_q.hs_on;
  assign ls_on_o = s_q.ls_on;
  assign ls_drive_o = ls_code; // [R1]
  assign hs_drive_o = bds_drive_t'(cfg_i.highside_slope_sel); // [R2]
  assign hs_threshold_high_o = cfg_i.hs_short_sensitivity; // [R9]
  assign status_o = s_q.st;
endmodule : bds_bridge
`default_nettype wire

// file: testbench/bds_bridge_checker.sv
`default_nettype none
module bds_bridge_checker
  import bds_pkg::*;
(
  input wire logic        clk_i,                  // Clock
  input wire logic        reset_i,                // Reset
  input wire logic        bridge_disable_n_pin_i, // Disable pin
  input wire bds_cfg_t    cfg_i,                  // Settings
  input wire logic [3:0]  hs_on_o,                // High gates
  input wire logic [3:0]  ls_on_o,                // Low gates
  input wire logic [1:0]  ls_drive_o,             // Low drive
  input wire bds_drive_t  hs_drive_o,             // High drive
  input wire logic        hs_threshold_high_o,    // Sensitivity
  input wire bds_status_t status_o                // Flags
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_dis; bridge_disable_n_pin_i [*5] |-> (hs_on_o | ls_on_o) == 4'h0; endproperty
  a_dis: assert property (p_dis) else $error("gate on while disabled");
  property p_chopper_off_time; cfg_i.chopper_off_time == 4'h0 [*2] |-> (hs_on_o | ls_on_o) == 4'h0; endproperty
  a_chopper_off_time: assert property (p_chopper_off_time) else $error("gate on with zero off time");
  property p_clr; bridge_disable_n_pin_i [*5] |-> status_o == 6'h00; endproperty
  a_clr: assert property (p_clr) else $error("flag kept while disabled");
  property p_bbm; (hs_on_o & ls_on_o) == 4'h0 && (ls_on_o & ~$past(ls_on_o) & $past(hs_on_o)) == 4'h0; endproperty
  a_bbm: assert property (p_bbm) else $error("cross conduction");
  property p_lsd; ls_drive_o == ((cfg_i.lowside_slope_sel == 2'h1) ? 2'h0 : cfg_i.lowside_slope_sel); endproperty
  a_lsd: assert property (p_lsd) else $error("low drive code");
  property p_hsd; hs_drive_o == bds_drive_t'(cfg_i.highside_slope_sel); endproperty
  a_hsd: assert property (p_hsd) else $error("high drive code");
  property p_sens; hs_threshold_high_o == cfg_i.hs_short_sensitivity; endproperty
  a_sens: assert property (p_sens) else $error("sensitivity");
  property p_pair; $rose(status_o.coil_a_short_flag) |-> status_o.coil_a_lowside_fault | status_o.coil_a_highside_fault;
  endproperty
  a_pair: assert property (p_pair) else $error("short flag without detail");
  property p_latch; status_o.coil_b_short_flag |=> (hs_on_o[3:2] | ls_on_o[3:2]) == 2'h0; endproperty
  a_latch: assert property (p_latch) else $error("shorted coil driven");
endmodule : bds_bridge_checker
bind bds_bridge bds_bridge_checker bds_bridge_checker_i (.clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg_i),
  .bridge_disable_n_pin_i(bridge_disable_n_pin_i), .hs_on_o(hs_on_o), .ls_on_o(ls_on_o), .ls_drive_o(ls_drive_o),
  .hs_drive_o(hs_drive_o), .hs_threshold_high_o(hs_threshold_high_o), .status_o(status_o));
`default_nettype wire

// file: testbench/bds_host.sv
`default_nettype none
module bds_host
  import bds_pkg::*;
(
  input  wire logic     dis_i, // Disable request
  input  wire bds_cfg_t req_i, // Wanted settings
  output logic          pin_o, // Disable pin
  output bds_cfg_t      cfg_o  // Programmed settings
);
  timeunit 1ns;
  timeprecision 100ps;
  always_comb begin
    pin_o = dis_i;
    cfg_o = req_i;
    cfg_o.highside_slope_sel = req_i.lowside_slope_sel;
  end
endmodule : bds_host
`default_nettype wire

// file: testbench/tb.sv
`default_nettype none
module tb
  import bds_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [1:0] code; logic [1:0] ls;} bds_row_t;
  bds_row_t    rows [4] = '{'{2'h0, 2'h0}, '{2'h1, 2'h0}, '{2'h2, 2'h2}, '{2'h3, 2'h3}};
  logic        clk, rst, dis, pin, thr;
  logic [3:0]  want, hgo, lgo, stk, hs_on, ls_on;
  logic [1:0]  hcl, hch, lc, lsd;
  bds_drive_t  hsd;
  bds_cfg_t    req, cfg;
  bds_status_t st;
  int          err_count = 0, compares = 0, cyc = 0, n;
  bds_host bds_host_i (.dis_i(dis), .req_i(req), .pin_o(pin), .cfg_o(cfg));
  bds_bridge bds_bridge_i (.clk_i(clk), .reset_i(rst), .bridge_disable_n_pin_i(pin), .cfg_i(cfg), .phase_hi_i(2'h0),
    .hs_want_i(want), .hs_gate_off_i(hgo), .ls_gate_off_i(lgo), .hs_cmp_low_i(hcl), .hs_cmp_high_i(hch),
    .ls_cmp_i(lc), .hs_on_o(hs_on), .ls_on_o(ls_on), .ls_drive_o(lsd), .hs_drive_o(hsd),
    .hs_threshold_high_o(thr), .status_o(st));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask : wt
  task automatic wflag(output int k);
    k = 0;
    while (st === 6'h00 && k < 2000) begin
      @(negedge clk);
      k++;
    end
  endtask : wflag
  task automatic tally_and_finish;
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Ideal gates; stk holds a high-side gate charged
  always @(negedge clk) begin
    hgo <= ~hs_on & ~stk;
    lgo <= ~ls_on;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish;
    end
  end
  initial begin
    rst = 1'b1; dis = 1'b0; req = '0; want = 4'h5; stk = 4'h0; hcl = 2'h0; hch = 2'h0; lc = 2'h0;
    hgo = 4'hF; lgo = 4'hF;
    wt(3);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      req.lowside_slope_sel = rows[i].code;
      req.hs_short_sensitivity = rows[i].code[0];
      wt(1);
      check("ls drive", lsd, rows[i].ls);
      check("hs drive", hsd, rows[i].code);
      check("sensitivity", thr, rows[i].code[0]);
    end
    req.chopper_off_time = 4'h4; req.lowside_short_enable = 1'b1; req.short_detect_delay = 2'h3;
    wt(10);
    check("gates", {hs_on, ls_on}, 8'h5A);
    stk = 4'h1; want = 4'h4; wt(12);
    check("ls held", ls_on[0], 1'b0);
    stk = 4'h0; wt(10);
    check("gates", {hs_on, ls_on}, 8'h4B);
    dis = 1'b1; wt(6);
    check("disabled", {hs_on, ls_on}, 8'h00);
    dis = 1'b0; wt(10);
    check("enabled", {hs_on, ls_on}, 8'h4B);
    req.chopper_off_time = 4'h0; wt(4);
    check("off time zero", {hs_on, ls_on}, 8'h00);
    req.chopper_off_time = 4'h4; lc = 2'h2; want = 4'h8; wflag(n);
    check("retry span", n >= 4 * DLY800_CYC && n <= 4 * DLY800_CYC + 60, 1'b1);
    check("flags b", st, 6'h14);
    lc = 2'h0; wt(20);
    check("coil b off", {hs_on, ls_on}, 8'h03);
    dis = 1'b1; wt(6);
    check("flags cleared", st, 6'h00);
    dis = 1'b0; wt(10);
    check("restart", {hs_on, ls_on}, 8'h87);
    req.lowside_short_enable = 1'b0; lc = 2'h3; want = 4'h7; wt(800);
    check("ls off", st, 6'h00);
    // Let the stale low-side fault drain through the synchroniser before the detector is enabled again
    lc = 2'h0; wt(4);
    req.lowside_short_enable = 1'b1; req.short_protect_disable = 1'b1; hcl = 2'h3; hch = 2'h3;
    want = 4'h8; wt(800);
    check("hs off", st, 6'h00);
    req.short_protect_disable = 1'b0; hcl = 2'h1; hch = 2'h1; want = 4'hB; wflag(n);
    check("flags a", st, 6'h22);
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
